// ---- dv/tb.sv ----
// Purpose: Self-checking bench of the timer event-flag block.
// Assumes: Strobe register port, read data in the cycle after the read strobe.
// Notes:   The free-run overflow check waits a whole 16-bit wrap, the bulk of the run.

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [tef_pkg::TEF_ADDR_W-1:0] i_addr = 4'h0;
    logic [tef_pkg::TEF_DATA_W-1:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [tef_pkg::TEF_NCH-1:0] i_ch_pin = 2'b00;
    logic [tef_pkg::TEF_DATA_W-1:0] o_rdata;
    logic o_irq;
    logic [15:0] rdv;
    logic seen_down;
    int err_total = 0;
    int checked = 0;

    always #25 i_clk = ~i_clk;

    tef_timer_event_flags i_dut (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .i_ch_pin(i_ch_pin),
        .o_rdata(o_rdata),
        .o_irq(o_irq)
    );

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        rdv = o_rdata;
    endtask

    task automatic clr;
        rd(tef_pkg::TEF_REG_STATUS);
        wr(tef_pkg::TEF_REG_STATUS, 16'h0000);
    endtask

    task automatic chk_reg(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_bit(input string nm, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %b seen %b", nm, exp, got);
        end
    endtask

    // Interrupt output is registered: look two edges after the write
    task automatic irq_is(input logic exp);
        repeat (2) @(posedge i_clk);
        #1;
        chk_bit("irq", exp, o_irq);
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge i_clk);
        i_arst_n <= 1'b1;
        wr(4'hF, 16'hFFFF);
        for (int a = 0; a < 9; a++) begin
            rd(a[3:0]);
            chk_reg("reset value", 16'h0000, rdv);
        end
        rd(4'hF);
        chk_reg("unmapped", 16'h0000, rdv);
        chk_bit("irq reset", 1'b0, o_irq);
        // Free-running count for the wrap check; capture flags do not need it
        wr(tef_pkg::TEF_REG_CNT, 16'h0000);
        wr(tef_pkg::TEF_REG_CTRL, 16'h0001);
        for (int e = 0; e < 4; e++) begin
            wr(tef_pkg::TEF_REG_CH_CTRL0, e[15:0]);
            clr;
            @(posedge i_clk);
            i_ch_pin[0] <= 1'b1;
            repeat (3) @(posedge i_clk);
            rd(tef_pkg::TEF_REG_STATUS);
            chk_reg("rise flag", {14'h0, e[0], 1'b0}, rdv & 16'h0002);
            clr;
            @(posedge i_clk);
            i_ch_pin[0] <= 1'b0;
            repeat (3) @(posedge i_clk);
            rd(tef_pkg::TEF_REG_STATUS);
            chk_reg("fall flag", {14'h0, e[1], 1'b0}, rdv & 16'h0002);
        end
        rd(tef_pkg::TEF_REG_STATUS);
        chk_reg("no early wrap", 16'h0000, rdv & 16'h0001);
        repeat (65536) @(posedge i_clk);
        rd(tef_pkg::TEF_REG_STATUS);
        chk_reg("full wrap", 16'h0001, rdv & 16'h0001);
        // Modulo 9; ch0 compare at 7, ch1 edge PWM at 3
        wr(tef_pkg::TEF_REG_CTRL, 16'h0000);
        wr(tef_pkg::TEF_REG_MOD, 16'h0009);
        wr(tef_pkg::TEF_REG_CH_VAL0, 16'h0007);
        wr(tef_pkg::TEF_REG_CH_CTRL0, 16'h0004);
        wr(4'h7, 16'h0003);
        wr(4'h6, 16'h0008);
        clr;
        wr(tef_pkg::TEF_REG_CNT, 16'h0000);
        wr(tef_pkg::TEF_REG_CTRL, 16'h0001);
        for (int k = 0; k < 8; k++) begin
            rd(tef_pkg::TEF_REG_CNT);
            chk_bit("count within modulo", 1'b1, rdv <= 16'h0009);
        end
        wr(tef_pkg::TEF_REG_CTRL, 16'h0000);
        wr(tef_pkg::TEF_REG_STATUS, 16'h0000);
        rd(tef_pkg::TEF_REG_STATUS);
        chk_reg("flags held", 16'h0007, rdv);
        wr(tef_pkg::TEF_REG_CTRL, 16'h0004);
        irq_is(1'b1);
        wr(tef_pkg::TEF_REG_CTRL, 16'h0000);
        irq_is(1'b0);
        wr(4'h6, 16'h0018);
        irq_is(1'b1);
        wr(tef_pkg::TEF_REG_STATUS, 16'h0000);
        irq_is(1'b0);
        rd(tef_pkg::TEF_REG_STATUS);
        chk_reg("flags cleared", 16'h0000, rdv);
        // Pin edges on a stopped counter: one between read and write, one on the write
        wr(tef_pkg::TEF_REG_CH_CTRL0, 16'h0003);
        i_ch_pin[0] <= 1'b1;
        rd(tef_pkg::TEF_REG_STATUS);
        @(posedge i_clk);
        i_ch_pin[0] <= 1'b0;
        wr(tef_pkg::TEF_REG_STATUS, 16'h0000);
        rd(tef_pkg::TEF_REG_STATUS);
        chk_reg("event keeps flag", 16'h0002, rdv & 16'h0002);
        fork
            wr(tef_pkg::TEF_REG_STATUS, 16'h0000);
            begin
                @(posedge i_clk);
                i_ch_pin[0] <= 1'b1;
            end
        join
        rd(tef_pkg::TEF_REG_STATUS);
        chk_reg("set wins clear", 16'h0002, rdv & 16'h0002);
        // Center mode, modulo 5, both channels at 2
        wr(tef_pkg::TEF_REG_CTRL, 16'h0000);
        wr(tef_pkg::TEF_REG_MOD, 16'h0005);
        wr(tef_pkg::TEF_REG_CH_VAL0, 16'h0002);
        wr(4'h7, 16'h0002);
        wr(tef_pkg::TEF_REG_CNT, 16'h0000);
        clr;
        wr(tef_pkg::TEF_REG_CTRL, 16'h0003);
        seen_down = 1'b0;
        for (int k = 0; k < 10; k++) begin
            rd(tef_pkg::TEF_REG_CNT);
            chk_bit("center count", 1'b1, rdv <= 16'h0005);
            rd(tef_pkg::TEF_REG_CTRL);
            seen_down = seen_down | rdv[3];
        end
        chk_bit("turned down", 1'b1, seen_down);
        wr(tef_pkg::TEF_REG_CTRL, 16'h0000);
        rd(tef_pkg::TEF_REG_STATUS);
        chk_reg("center flags", 16'h0007, rdv);
        test_done;
    end

    // Whole run is about 66k cycles; this cuts a hang short
    initial begin
        repeat (80000) @(posedge i_clk);
        err_total++;
        $display("[FAIL] watchdog expected finish seen hang");
        test_done;
    end
endmodule

bind tef_timer_event_flags tef_flags_sva i_sva (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_ch_pin(i_ch_pin),
    .o_rdata(o_rdata),
    .o_irq(o_irq)
);

// ---- dv/tef_flags_sva.sv ----
// Purpose: Port-level checks of the timer event-flag block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Shadows only the control bits, enables and modulo that software writes.

module tef_flags_sva (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [tef_pkg::TEF_ADDR_W-1:0] i_addr,
    input wire logic [tef_pkg::TEF_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [tef_pkg::TEF_NCH-1:0] i_ch_pin,
    input wire logic [tef_pkg::TEF_DATA_W-1:0] o_rdata,
    input wire logic o_irq
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Shadow of software writes
    // ------------------------------------------------------------
    logic [2:0] ctrl_q;
    logic [1:0] ch_ie;
    logic [15:0] mod_q;
    logic any_en;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_q <= 3'h0;
            ch_ie <= 2'h0;
            mod_q <= 16'h0000;
        end else if (i_wr) begin
            if (i_addr == tef_pkg::TEF_REG_CTRL) ctrl_q <= i_wdata[2:0];
            if (i_addr == tef_pkg::TEF_REG_MOD) mod_q <= i_wdata;
            if (i_addr == tef_pkg::TEF_REG_CH_CTRL0) ch_ie[0] <= i_wdata[4];
            if (i_addr == 4'h6) ch_ie[1] <= i_wdata[4];
        end
    end

    // Enables alone decide whether a set flag may reach the output
    assign any_en = ctrl_q[2] | ch_ie[0] | ch_ie[1];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data not zero outside the read answer cycle");
    a_unmapped_read: assert property ($past(i_rd) && $past(i_addr) > 4'h7 |-> o_rdata == 16'h0000)
        else $error("unmapped read returned nonzero data");
    a_ctrl_readback: assert property ($past(i_rd) && $past(i_addr) == tef_pkg::TEF_REG_CTRL
        |-> o_rdata[2:0] == $past(ctrl_q) && o_rdata[15:4] == 12'h000)
        else $error("control read does not match written bits");
    a_mod_readback: assert property ($past(i_rd) && $past(i_addr) == tef_pkg::TEF_REG_MOD
        |-> o_rdata == $past(mod_q))
        else $error("modulo read does not match written value");
    a_status_upper_zero: assert property ($past(i_rd) && $past(i_addr) == tef_pkg::TEF_REG_STATUS
        |-> o_rdata[15:3] == 13'h0000)
        else $error("status read shows bits above the flags");
    a_irq_after_reset: assert property (!$past(i_arst_n) |-> !o_irq)
        else $error("interrupt high right after reset");
    a_irq_masked_low: assert property (!any_en && !$past(any_en) |-> !o_irq)
        else $error("interrupt high with every enable clear");
    a_irq_level_hold: assert property (o_irq && !i_wr && !$past(i_wr) |=> o_irq)
        else $error("interrupt dropped without any register write");
    a_irq_drop_cause: assert property ($fell(o_irq) |-> $past(i_wr, 2))
        else $error("interrupt fell two cycles after no write");
endmodule

// ---- hdl/tef_chan_event.sv ----
// Purpose: Event detector of one timer channel.
// Assumes: Input pin synchronous to i_clk; count advances one step per clock.
// Notes:   o_event is combinational; the top registers it into a flag.

module tef_chan_event (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_run,
    input wire logic i_center,
    input wire logic [1:0] i_mode_sel,
    input wire logic i_els_hi,
    input wire logic i_els_lo,
    input wire logic i_pin,
    input wire logic [tef_pkg::TEF_CNT_W-1:0] i_count,
    input wire logic [tef_pkg::TEF_CNT_W-1:0] i_chval,
    output logic o_event,
    output logic o_capture
);

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    tef_pkg::tef_chmode_e mode;
    logic pin_prev;
    logic rise;
    logic fall;
    logic edge_hit;
    logic match;

    always_comb begin
        if (i_center) begin
            mode = tef_pkg::TEF_MODE_CENTER_PWM;
        end else if (i_mode_sel[1]) begin
            mode = tef_pkg::TEF_MODE_EDGE_PWM;
        end else if (i_mode_sel[0]) begin
            mode = tef_pkg::TEF_MODE_COMPARE;
        end else begin
            mode = tef_pkg::TEF_MODE_CAPTURE;
        end
    end

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_prev <= 1'b0;
        end else begin
            pin_prev <= i_pin;
        end
    end

    assign rise = i_pin & ~pin_prev;
    assign fall = ~i_pin & pin_prev;

    always_comb begin
        unique case ({i_els_hi, i_els_lo})
            2'b00: edge_hit = 1'b0;
            2'b01: edge_hit = rise;
            2'b10: edge_hit = fall;
            2'b11: edge_hit = rise | fall;
        endcase
    end

    // Match only counts while the counter steps, so a held count gives no event
    assign match = i_run && (i_count == i_chval);

    always_comb begin
        o_capture = 1'b0;
        unique case (mode)
            tef_pkg::TEF_MODE_CAPTURE: begin
                o_event = edge_hit;
                o_capture = edge_hit;
            end
            tef_pkg::TEF_MODE_COMPARE: begin
                o_event = match;
            end
            tef_pkg::TEF_MODE_EDGE_PWM: begin
                o_event = match;
            end
            tef_pkg::TEF_MODE_CENTER_PWM: begin
                // Counter passes the value once up and once down per period
                o_event = match;
            end
        endcase
    end

endmodule

// ---- hdl/tef_pkg.sv ----
// Purpose: Shared constants and types of the timer event-flag block.
// Assumes: One 20 MHz clock; registers reached over a plain strobe port.
// Notes:   Register indices and field positions live here only.

package tef_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int TEF_CNT_W = 16;
    localparam int TEF_ADDR_W = 4;
    localparam int TEF_DATA_W = 16;
    localparam int TEF_NCH = 2;
    localparam int TEF_NFLAG = TEF_NCH + 1;

    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [TEF_ADDR_W-1:0] TEF_REG_CTRL = 4'h0;
    localparam logic [TEF_ADDR_W-1:0] TEF_REG_MOD = 4'h1;
    localparam logic [TEF_ADDR_W-1:0] TEF_REG_CNT = 4'h2;
    localparam logic [TEF_ADDR_W-1:0] TEF_REG_STATUS = 4'h3;
    localparam logic [TEF_ADDR_W-1:0] TEF_REG_CH_CTRL0 = 4'h4;
    localparam logic [TEF_ADDR_W-1:0] TEF_REG_CH_VAL0 = 4'h5;
    localparam logic [TEF_ADDR_W-1:0] TEF_REG_CH_STRIDE = 4'h2;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TEF_CTRL_RUN = 0;
    localparam int TEF_CTRL_CENTER = 1;
    localparam int TEF_CTRL_OVF_IE = 2;
    localparam int TEF_CTRL_DIR_DOWN = 3;
    localparam int TEF_CH_ELS_LO = 0;
    localparam int TEF_CH_ELS_HI = 1;
    localparam int TEF_CH_MODE_LO = 2;
    localparam int TEF_CH_MODE_HI = 3;
    localparam int TEF_CH_IE = 4;
    localparam int TEF_CH_CTRL_W = 5;
    localparam int TEF_STAT_OVF = 0;
    localparam int TEF_STAT_CH0 = 1;

    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [TEF_CNT_W-1:0] TEF_CNT_ZERO = 16'h0000;
    localparam logic [TEF_CNT_W-1:0] TEF_CNT_FULL = 16'hFFFF;
    localparam logic [TEF_CNT_W-1:0] TEF_CNT_ONE = 16'h0001;
    localparam logic [TEF_DATA_W-1:0] TEF_RD_ZERO = 16'h0000;
    localparam logic [TEF_CH_CTRL_W-1:0] TEF_CH_CTRL_RST = 5'h00;

    // Channel behaviour chosen from mode bits and the center select
    typedef enum logic [1:0] {
        TEF_MODE_CAPTURE,
        TEF_MODE_COMPARE,
        TEF_MODE_EDGE_PWM,
        TEF_MODE_CENTER_PWM
    } tef_chmode_e;

endpackage

// ---- hdl/tef_timer_event_flags.sv ----
// Purpose: Counter, overflow and channel event flags of a 16-bit timer.
// Assumes: Software reaches registers over a plain strobe port, data next cycle.
// Notes:   Flags clear by a read-while-set followed by a write of zero.

// Summary of operation
// - Outside center mode the overflow flag sets when the count rolls from modulo to zero.
// - With modulo zero the counter runs free and the flag sets on the roll from all ones.
// - In center mode the overflow flag sets when the count turns down at the modulo value.
// - In capture mode the two edge bits pick off, rising, falling or both edges.
// - In capture mode a selected edge on the pin sets the channel flag.
// - In compare mode every running cycle with count equal to the channel value sets the flag.
// - In edge PWM mode the flag sets when the count equals the channel value.
// - In center PWM mode the flag sets at both matches, counting up and counting down.
// - A flag clears by reading it set then writing zero; an event in between keeps it.
// - While a flag and its enable are set the interrupt request stays high.
// - In center mode the counter counts up to modulo then down to zero, repeatedly.
module tef_timer_event_flags (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [tef_pkg::TEF_ADDR_W-1:0] i_addr,
    input wire logic [tef_pkg::TEF_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [tef_pkg::TEF_NCH-1:0] i_ch_pin,
    output logic [tef_pkg::TEF_DATA_W-1:0] o_rdata,
    output logic o_irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic run;
    logic center_align_select;
    logic overflow_irq_enable;
    logic dir_down;
    logic [tef_pkg::TEF_CNT_W-1:0] modulo;
    logic [tef_pkg::TEF_CNT_W-1:0] count;
    logic [tef_pkg::TEF_CNT_W-1:0] next_count;
    logic next_dir_down;
    logic [tef_pkg::TEF_CNT_W-1:0] terminal;
    logic at_terminal;
    logic ovf_event;
    logic cnt_wr;
    logic [tef_pkg::TEF_CH_CTRL_W-1:0] ch_ctrl [tef_pkg::TEF_NCH];
    logic [tef_pkg::TEF_CNT_W-1:0] ch_val [tef_pkg::TEF_NCH];
    logic [tef_pkg::TEF_NCH-1:0] ch_event;
    logic [tef_pkg::TEF_NCH-1:0] ch_capture;
    logic [tef_pkg::TEF_NCH-1:0] channel_irq_enable;
    logic [tef_pkg::TEF_NFLAG-1:0] flag_event;
    logic [tef_pkg::TEF_NFLAG-1:0] flag;
    logic [tef_pkg::TEF_NFLAG-1:0] armed;
    logic [tef_pkg::TEF_NFLAG-1:0] flag_en;
    logic status_rd;
    logic status_wr;
    logic [tef_pkg::TEF_DATA_W-1:0] next_rdata;
    logic counter_overflow_flag;
    logic [tef_pkg::TEF_NCH-1:0] channel_event_flag;

    assign cnt_wr = i_wr && (i_addr == tef_pkg::TEF_REG_CNT);
    assign status_rd = i_rd && (i_addr == tef_pkg::TEF_REG_STATUS);
    assign status_wr = i_wr && (i_addr == tef_pkg::TEF_REG_STATUS);

    // ------------------------------------------------------------
    // Global control and modulo
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run <= 1'b0;
            center_align_select <= 1'b0;
            overflow_irq_enable <= 1'b0;
        end else if (i_wr && (i_addr == tef_pkg::TEF_REG_CTRL)) begin
            run <= i_wdata[tef_pkg::TEF_CTRL_RUN];
            center_align_select <= i_wdata[tef_pkg::TEF_CTRL_CENTER];
            overflow_irq_enable <= i_wdata[tef_pkg::TEF_CTRL_OVF_IE];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            modulo <= tef_pkg::TEF_CNT_ZERO;
        end else if (i_wr && (i_addr == tef_pkg::TEF_REG_MOD)) begin
            modulo <= i_wdata;
        end
    end

    // ------------------------------------------------------------
    // Main counter
    // ------------------------------------------------------------
    // Modulo zero means the full 16-bit range in up-counting mode
    assign terminal = (modulo == tef_pkg::TEF_CNT_ZERO) ? tef_pkg::TEF_CNT_FULL : modulo;
    assign at_terminal = (count == terminal);

    always_comb begin
        next_count = count;
        next_dir_down = dir_down;
        ovf_event = 1'b0;
        if (run) begin
            if (!center_align_select) begin
                next_dir_down = 1'b0;
                if (at_terminal) begin
                    next_count = tef_pkg::TEF_CNT_ZERO;
                    ovf_event = 1'b1;
                end else begin
                    next_count = count + tef_pkg::TEF_CNT_ONE;
                end
            end else if (!dir_down) begin
                // Modulo zero is unusable here: no turn point other than zero
                if (count == modulo) begin
                    next_dir_down = 1'b1;
                    next_count = count - tef_pkg::TEF_CNT_ONE;
                    ovf_event = 1'b1;
                end else begin
                    next_count = count + tef_pkg::TEF_CNT_ONE;
                end
            end else begin
                if (count == tef_pkg::TEF_CNT_ZERO) begin
                    next_dir_down = 1'b0;
                    next_count = count + tef_pkg::TEF_CNT_ONE;
                end else begin
                    next_count = count - tef_pkg::TEF_CNT_ONE;
                end
            end
        end
    end

    // Any write to the count register restarts it from zero counting up
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count <= tef_pkg::TEF_CNT_ZERO;
            dir_down <= 1'b0;
        end else if (cnt_wr) begin
            count <= tef_pkg::TEF_CNT_ZERO;
            dir_down <= 1'b0;
        end else begin
            count <= next_count;
            dir_down <= next_dir_down;
        end
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    generate
        for (genvar ch = 0; ch < tef_pkg::TEF_NCH; ch++) begin : g_ch
            localparam logic [tef_pkg::TEF_ADDR_W-1:0] CTRL_ADDR =
                tef_pkg::TEF_REG_CH_CTRL0 + tef_pkg::TEF_ADDR_W'(ch * tef_pkg::TEF_REG_CH_STRIDE);
            localparam logic [tef_pkg::TEF_ADDR_W-1:0] VAL_ADDR =
                tef_pkg::TEF_REG_CH_VAL0 + tef_pkg::TEF_ADDR_W'(ch * tef_pkg::TEF_REG_CH_STRIDE);

            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    ch_ctrl[ch] <= tef_pkg::TEF_CH_CTRL_RST;
                end else if (i_wr && (i_addr == CTRL_ADDR)) begin
                    ch_ctrl[ch] <= i_wdata[tef_pkg::TEF_CH_CTRL_W-1:0];
                end
            end

            // A capture wins over a software write in the same cycle
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    ch_val[ch] <= tef_pkg::TEF_CNT_ZERO;
                end else if (ch_capture[ch]) begin
                    ch_val[ch] <= count;
                end else if (i_wr && (i_addr == VAL_ADDR)) begin
                    ch_val[ch] <= i_wdata;
                end
            end

            assign channel_irq_enable[ch] = ch_ctrl[ch][tef_pkg::TEF_CH_IE];

            tef_chan_event u_event (
                .i_clk(i_clk),
                .i_arst_n(i_arst_n),
                .i_run(run),
                .i_center(center_align_select),
                .i_mode_sel(ch_ctrl[ch][tef_pkg::TEF_CH_MODE_HI:tef_pkg::TEF_CH_MODE_LO]),
                .i_els_hi(ch_ctrl[ch][tef_pkg::TEF_CH_ELS_HI]),
                .i_els_lo(ch_ctrl[ch][tef_pkg::TEF_CH_ELS_LO]),
                .i_pin(i_ch_pin[ch]),
                .i_count(count),
                .i_chval(ch_val[ch]),
                .o_event(ch_event[ch]),
                .o_capture(ch_capture[ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------
    assign flag_event = {ch_event, ovf_event};
    assign flag_en = {channel_irq_enable, overflow_irq_enable};

    generate
        for (genvar f = 0; f < tef_pkg::TEF_NFLAG; f++) begin : g_flag
            // Reading the flag while set arms the clear; a new event disarms it
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    armed[f] <= 1'b0;
                end else if (flag_event[f]) begin
                    armed[f] <= 1'b0;
                end else if (status_rd && flag[f]) begin
                    armed[f] <= 1'b1;
                end else if (status_wr) begin
                    armed[f] <= 1'b0;
                end
            end

            // Set wins over a clear in the same cycle so no event is lost
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    flag[f] <= 1'b0;
                end else if (flag_event[f]) begin
                    flag[f] <= 1'b1;
                end else if (status_wr && armed[f] &&
                             !i_wdata[tef_pkg::TEF_STAT_OVF + f]) begin
                    flag[f] <= 1'b0;
                end
            end
        end
    endgenerate

    assign counter_overflow_flag = flag[tef_pkg::TEF_STAT_OVF];
    assign channel_event_flag = flag[tef_pkg::TEF_NFLAG-1:tef_pkg::TEF_STAT_CH0];

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------
    // Registered, so the request follows the flag by one cycle
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(flag & flag_en);
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = tef_pkg::TEF_RD_ZERO;
        unique case (i_addr)
            tef_pkg::TEF_REG_CTRL: begin
                next_rdata[tef_pkg::TEF_CTRL_RUN] = run;
                next_rdata[tef_pkg::TEF_CTRL_CENTER] = center_align_select;
                next_rdata[tef_pkg::TEF_CTRL_OVF_IE] = overflow_irq_enable;
                next_rdata[tef_pkg::TEF_CTRL_DIR_DOWN] = dir_down;
            end
            tef_pkg::TEF_REG_MOD: begin
                next_rdata = modulo;
            end
            tef_pkg::TEF_REG_CNT: begin
                next_rdata = count;
            end
            tef_pkg::TEF_REG_STATUS: begin
                next_rdata[tef_pkg::TEF_STAT_OVF] = counter_overflow_flag;
                next_rdata[tef_pkg::TEF_NFLAG-1:tef_pkg::TEF_STAT_CH0] = channel_event_flag;
            end
            tef_pkg::TEF_REG_CH_CTRL0: begin
                next_rdata[tef_pkg::TEF_CH_CTRL_W-1:0] = ch_ctrl[0];
            end
            tef_pkg::TEF_REG_CH_VAL0: begin
                next_rdata = ch_val[0];
            end
            tef_pkg::TEF_REG_CH_CTRL0 + tef_pkg::TEF_REG_CH_STRIDE: begin
                next_rdata[tef_pkg::TEF_CH_CTRL_W-1:0] = ch_ctrl[1];
            end
            tef_pkg::TEF_REG_CH_VAL0 + tef_pkg::TEF_REG_CH_STRIDE: begin
                next_rdata = ch_val[1];
            end
            default: begin
                next_rdata = tef_pkg::TEF_RD_ZERO;
            end
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= tef_pkg::TEF_RD_ZERO;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= tef_pkg::TEF_RD_ZERO;
        end
    end

endmodule
